// ===== verilog/rp_sideband_pkg.sv
// Purpose: Shared constants for the root port interrupt and error sideband
// Assumes: Single clock domain, inputs synchronous to the clock
// Notes:   Message kinds and field widths live here
package rp_sideband_pkg;
    localparam int INTX_W       = 4;
    localparam int MSI_NUM_W    = 5;
    localparam int CPL_ERR_W    = 7;
    localparam int FUNC_W       = 3;
    localparam int NUM_FUNC     = 8;
    localparam int CPL_SPACING  = 8;
    localparam int SPC_W        = 4;
    localparam int BIT_CTO_COR  = 0;
    localparam int BIT_CTO_UNC  = 1;
    localparam int BIT_CA       = 2;
    localparam int BIT_UNEXP    = 3;
    localparam int BIT_UR_P     = 4;
    localparam int BIT_UR_NP    = 5;
    localparam int BIT_LOG_HDR  = 6;
    localparam logic [4:0] MSI_EN_ALL = 5'h1F;
    localparam logic [3:0] SPC_RST    = 4'h0;
    typedef enum logic [2:0] {
        MSG_NONE,
        MSG_COR,
        MSG_NONFATAL,
        MSG_FATAL
    } err_msg_t;
    typedef enum logic [1:0] {
        SEV_COR,
        SEV_NONFATAL,
        SEV_FATAL
    } sev_t;
endpackage : rp_sideband_pkg

// ===== verilog/rp_sideband.sv
// Purpose: Root port legacy interrupt, system error and completion error sideband
// Assumes: All inputs synchronous to CLK_IN; application keeps its own timing
// Notes:   Error status bits are sticky per function until cleared by config writes
//
// Behaviour
// - Four legacy interrupts on bits A to D
// - Error MSI number masked by enabled bits
// - Capability MSI number masked by enabled bits
// - System error pulses exactly one cycle
// - Bit 1 sends a non-advisory error message
// - Any of error bits 0 to 5 sets status and messages; bit 6 does not
`timescale 1ns/1ns
module rp_sideband
    import rp_sideband_pkg::*;
(
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_B_IN,
    input  wire logic [INTX_W-1:0]    INTX_ASSERT_IN,
    input  wire logic [INTX_W-1:0]    INTX_DEASSERT_IN,
    output logic      [INTX_W-1:0]    INT_STATUS_OUT,
    input  wire logic [MSI_NUM_W-1:0] AER_MSI_NUM_IN,
    input  wire logic [MSI_NUM_W-1:0] CAP_MSI_NUM_IN,
    input  wire logic [MSI_NUM_W-1:0] MSI_NUM_EN_IN,
    output logic      [MSI_NUM_W-1:0] AER_MSI_DATA_OUT,
    output logic      [MSI_NUM_W-1:0] CAP_MSI_DATA_OUT,
    input  wire logic                 SYS_ERR_DET_IN,
    input  wire logic                 ROOT_SERR_EN_IN,
    input  wire logic                 DEV_SERR_EN_IN,
    output logic                      SERR_OUT,
    input  wire logic [CPL_ERR_W-1:0] CPL_ERR_IN,
    input  wire logic [FUNC_W-1:0]    CPL_ERR_FUNC_IN,
    input  wire logic                 STATUS_CLR_IN,
    input  wire logic [FUNC_W-1:0]    STATUS_CLR_FUNC_IN,
    output logic                      ERR_MSG_VALID_OUT,
    output err_msg_t                  ERR_MSG_KIND_OUT,
    output logic                      ERR_MSG_ADVISORY_OUT,
    output logic      [FUNC_W-1:0]    ERR_MSG_FUNC_OUT,
    output logic      [CPL_ERR_W-2:0] ERR_STATUS_OUT [NUM_FUNC],
    output logic                      CPL_ERR_SPACING_VIOL_OUT
);
    import rp_sideband_pkg::*;

    // Widths are fixed by the pin map; the spacing reload must fit its counter
    if (INTX_W != 4 || MSI_NUM_W != 5 || CPL_ERR_W != 7 || NUM_FUNC != (1 << FUNC_W) ||
        CPL_SPACING < 1 || CPL_SPACING > (1 << SPC_W))
    begin : g_bad_sizes
        $error("rp_sideband: unsupported sizes");
    end

    // Severity of each reported completion error; UR on posted is non-fatal here
    function automatic err_msg_t kind_of(input logic [CPL_ERR_W-1:0] e);
        if (e[BIT_CTO_UNC] || e[BIT_UNEXP] || e[BIT_UR_P] || e[BIT_UR_NP] || e[BIT_CA])
            kind_of = MSG_NONFATAL;
        else if (e[BIT_CTO_COR])
            kind_of = MSG_COR;
        else
            kind_of = MSG_NONE;
    endfunction : kind_of

    // Only message-data bits that the MSI control setting enables pass
    function automatic logic [MSI_NUM_W-1:0] mask_msi(input logic [MSI_NUM_W-1:0] num,
                                                      input logic [MSI_NUM_W-1:0] en);
        mask_msi = num & en;
    endfunction : mask_msi

    logic [INTX_W-1:0]    intx_r,    intx_nxt;
    logic [MSI_NUM_W-1:0] aer_r,     aer_nxt;
    logic [MSI_NUM_W-1:0] cap_r,     cap_nxt;
    logic                 serr_r,    serr_nxt;
    logic                 sys_d_r,   sys_d_nxt;
    logic                 mval_r,    mval_nxt;
    err_msg_t             mkind_r,   mkind_nxt;
    logic                 madv_r,    madv_nxt;
    logic [FUNC_W-1:0]    mfunc_r,   mfunc_nxt;
    logic [CPL_ERR_W-2:0] sts_r [NUM_FUNC];
    logic [CPL_ERR_W-2:0] sts_nxt [NUM_FUNC];
    logic [SPC_W-1:0]     spc_r,     spc_nxt;
    logic                 viol_r,    viol_nxt;

    wire  logic           any_err = |CPL_ERR_IN[CPL_ERR_W-2:0];
    // Reload of the spacing counter; the size check above keeps it in range
    localparam logic [SPC_W-1:0] SPC_SPAN = SPC_W'(CPL_SPACING - 1);

    always_comb
    begin
        // Level held from assert until the matching deassert message
        intx_nxt = (intx_r | INTX_ASSERT_IN) & ~INTX_DEASSERT_IN;
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            intx_r <= '0;
        else
            intx_r <= intx_nxt;
    end

    always_comb
    begin
        aer_nxt = mask_msi(AER_MSI_NUM_IN, MSI_NUM_EN_IN);
        cap_nxt = mask_msi(CAP_MSI_NUM_IN, MSI_NUM_EN_IN);
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            aer_r <= '0;
            cap_r <= '0;
        end
        else
        begin
            aer_r <= aer_nxt;
            cap_r <= cap_nxt;
        end
    end

    always_comb
    begin
        // Edge of the detect level so a long detect still gives one pulse
        sys_d_nxt = SYS_ERR_DET_IN;
        serr_nxt  = SYS_ERR_DET_IN && !sys_d_r && ROOT_SERR_EN_IN && DEV_SERR_EN_IN;
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            serr_r  <= 1'b0;
            sys_d_r <= 1'b0;
        end
        else
        begin
            serr_r  <= serr_nxt;
            sys_d_r <= sys_d_nxt;
        end
    end

    always_comb
    begin
        spc_nxt  = (spc_r == SPC_RST) ? SPC_RST : spc_r - SPC_W'(1);
        viol_nxt = 1'b0;
        if (any_err)
        begin
            // Still accepted, but flagged: the window is a far-side duty
            viol_nxt = (spc_r != SPC_RST);
            spc_nxt  = SPC_SPAN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            spc_r  <= SPC_RST;
            viol_r <= 1'b0;
        end
        else
        begin
            spc_r  <= spc_nxt;
            viol_r <= viol_nxt;
        end
    end

    always_comb
    begin
        mval_nxt  = 1'b0;
        mkind_nxt = MSG_NONE;
        madv_nxt  = 1'b0;
        mfunc_nxt = mfunc_r;
        if (any_err)
        begin
            // Function taken with the error in the same cycle
            mfunc_nxt = CPL_ERR_FUNC_IN;
            mval_nxt  = 1'b1;
            mkind_nxt = kind_of(CPL_ERR_IN);
            // Correctable timeout without bit 1 is advisory; bit 1 never is
            madv_nxt  = CPL_ERR_IN[BIT_CTO_COR] && !CPL_ERR_IN[BIT_CTO_UNC];
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            mval_r  <= 1'b0;
            mkind_r <= MSG_NONE;
            madv_r  <= 1'b0;
            mfunc_r <= '0;
        end
        else
        begin
            mval_r  <= mval_nxt;
            mkind_r <= mkind_nxt;
            madv_r  <= madv_nxt;
            mfunc_r <= mfunc_nxt;
        end
    end

    // One status slice per function; clear first so a same-cycle set wins
    for (genvar g = 0; g < NUM_FUNC; g++)
    begin : g_status
        always_comb
        begin
            sts_nxt[g] = sts_r[g];
            if (STATUS_CLR_IN && STATUS_CLR_FUNC_IN == FUNC_W'(g))
                sts_nxt[g] = '0;
            if (any_err && CPL_ERR_FUNC_IN == FUNC_W'(g))
                sts_nxt[g] = sts_nxt[g] | CPL_ERR_IN[CPL_ERR_W-2:0];
        end

        always_ff @(posedge CLK_IN or negedge RST_B_IN)
        begin
            if (!RST_B_IN)
                sts_r[g] <= '0;
            else
                sts_r[g] <= sts_nxt[g];
        end
    end

    assign INT_STATUS_OUT           = intx_r;
    assign AER_MSI_DATA_OUT         = aer_r;
    assign CAP_MSI_DATA_OUT         = cap_r;
    assign SERR_OUT                 = serr_r;
    assign ERR_MSG_VALID_OUT        = mval_r;
    assign ERR_MSG_KIND_OUT         = mkind_r;
    assign ERR_MSG_ADVISORY_OUT     = madv_r;
    assign ERR_MSG_FUNC_OUT         = mfunc_r;
    assign ERR_STATUS_OUT           = sts_r;
    assign CPL_ERR_SPACING_VIOL_OUT = viol_r;
endmodule : rp_sideband

// ===== bench/rp_sideband_sva.sv
// Purpose: Port checks for the sideband; Assumes: one clock; Notes: bound after endmodule
`timescale 1ns/1ns
module rp_sideband_sva
    import rp_sideband_pkg::*;
(
    input wire logic       CLK_IN, RST_B_IN, SYS_ERR_DET_IN, ROOT_SERR_EN_IN, DEV_SERR_EN_IN,
    input wire logic       SERR_OUT, ERR_MSG_VALID_OUT, ERR_MSG_ADVISORY_OUT,
    input wire logic [3:0] INTX_ASSERT_IN, INTX_DEASSERT_IN, INT_STATUS_OUT,
    input wire logic [4:0] AER_MSI_NUM_IN, MSI_NUM_EN_IN, AER_MSI_DATA_OUT,
    input wire logic [6:0] CPL_ERR_IN,
    input wire err_msg_t   ERR_MSG_KIND_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    logic [3:0] set_only;
    assign set_only = INTX_ASSERT_IN & ~INTX_DEASSERT_IN;
    property p_int_set; |set_only |=> (INT_STATUS_OUT & $past(set_only)) == $past(set_only);
    endproperty
    a_int_set: assert property (p_int_set) else $error("int not set");
    property p_int_clr; |INTX_DEASSERT_IN |=> !(INT_STATUS_OUT & $past(INTX_DEASSERT_IN));
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("int not cleared");
    property p_int_hold; !(INTX_ASSERT_IN | INTX_DEASSERT_IN) |=> $stable(INT_STATUS_OUT);
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("int moved");
    property p_aer; 1'b1 |=> AER_MSI_DATA_OUT == ($past(AER_MSI_NUM_IN) & $past(MSI_NUM_EN_IN));
    endproperty
    a_aer: assert property (p_aer) else $error("aer data wrong");
    property p_serr_one; SERR_OUT |=> !SERR_OUT; endproperty
    a_serr_one: assert property (p_serr_one) else $error("serr too long");
    property p_serr_set; $rose(SYS_ERR_DET_IN) && ROOT_SERR_EN_IN && DEV_SERR_EN_IN |=> SERR_OUT;
    endproperty
    a_serr_set: assert property (p_serr_set) else $error("serr missing");
    property p_serr_why; SERR_OUT |-> $past(ROOT_SERR_EN_IN) && $past(DEV_SERR_EN_IN); endproperty
    a_serr_why: assert property (p_serr_why) else $error("serr not enabled");
    property p_cor; CPL_ERR_IN[5:0] == 6'h01 |=> ERR_MSG_ADVISORY_OUT && ERR_MSG_KIND_OUT == MSG_COR;
    endproperty
    a_cor: assert property (p_cor) else $error("advisory msg wrong");
    property p_unc; CPL_ERR_IN[1] |=> ERR_MSG_VALID_OUT && !ERR_MSG_ADVISORY_OUT; endproperty
    a_unc: assert property (p_unc) else $error("non-advisory msg wrong");
endmodule : rp_sideband_sva
bind rp_sideband rp_sideband_sva i_sva (.*);

// ===== bench/rp_app_model.sv
// Purpose: Application side; Assumes: bench asks via req_in; Notes: asks under spacing dropped unless rush_in
`timescale 1ns/1ns
module rp_app_model
    import rp_sideband_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       req_in,
    input  wire logic       rush_in,
    input  wire logic [6:0] code_in,
    input  wire logic [2:0] func_in,
    output logic      [6:0] cpl_err_out = 7'h00,
    output logic      [2:0] func_out = 3'h0
);
    // Codes 01 and 02 stand for correctable and uncorrectable timeouts
    // Rush skips the spacing on purpose so the violation flag gets exercised
    // Rejected requests are answered on the packet path, never here
    int gap = CPL_SPACING;
    logic go;
    logic [6:0] code_s;
    logic [2:0] func_s;
    always @(posedge clk_in)
    begin
        gap = gap + 1;
        go = req_in && (gap >= CPL_SPACING || rush_in);
        code_s = code_in;
        func_s = func_in;
        #1;
        cpl_err_out = go ? code_s : 7'h00;
        func_out = go ? func_s : ~func_out;
        if (go) gap = 0;
    end
endmodule : rp_app_model

// ===== bench/rp_sideband_tb.sv
// Purpose: Random and table bench; Assumes: outputs settle by falling edge; Notes: none
`timescale 1ns/1ns
module rp_sideband_tb;
    import rp_sideband_pkg::*;
    logic CLK_IN = 1'b0, RST_B_IN = 1'b0, req = 1'b0, e_serr, e_val, e_adv, e_ck, ldet;
    logic SYS_ERR_DET_IN, ROOT_SERR_EN_IN, DEV_SERR_EN_IN, STATUS_CLR_IN, SERR_OUT;
    logic ERR_MSG_VALID_OUT, ERR_MSG_ADVISORY_OUT, CPL_ERR_SPACING_VIOL_OUT;
    logic [3:0] INTX_ASSERT_IN, INTX_DEASSERT_IN, INT_STATUS_OUT, e_int;
    logic [4:0] AER_MSI_NUM_IN, CAP_MSI_NUM_IN, MSI_NUM_EN_IN, AER_MSI_DATA_OUT, e_aer;
    logic [4:0] CAP_MSI_DATA_OUT, e_cap;
    logic [6:0] CPL_ERR_IN, code = 7'h00;
    logic [2:0] CPL_ERR_FUNC_IN, STATUS_CLR_FUNC_IN, ERR_MSG_FUNC_OUT, func, e_func;
    err_msg_t ERR_MSG_KIND_OUT, e_kind;
    logic [5:0] ERR_STATUS_OUT [NUM_FUNC], e_st [NUM_FUNC];
    logic [6:0] tab [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h3F, 7'h41};
    logic [31:0] seed = 32'h0000F7F1, r;
    int num_errors = 0, n_tests = 0;
    logic rush = 1'b0, e_viol;
    int e_since = 0;
    rp_sideband i_dut (.*);
    rp_app_model i_app (.clk_in(CLK_IN), .req_in(req), .code_in(code), .func_in(func),
                        .rush_in(rush), .cpl_err_out(CPL_ERR_IN), .func_out(CPL_ERR_FUNC_IN));
    initial forever #2 CLK_IN = ~CLK_IN;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n, input bit rnd);
        repeat (n)
        begin
            @(posedge CLK_IN);
            #1;
            r = xs();
            {INTX_ASSERT_IN, INTX_DEASSERT_IN} = r[7:0] & r[15:8] & r[23:16];
            r = xs();
            {AER_MSI_NUM_IN, CAP_MSI_NUM_IN, MSI_NUM_EN_IN, func} = r[17:0];
            {ROOT_SERR_EN_IN, DEV_SERR_EN_IN} = {r[19] | r[20], r[21] | r[22]};
            {STATUS_CLR_IN, STATUS_CLR_FUNC_IN, SYS_ERR_DET_IN} = {&r[25:23], r[28:26], r[29]};
            if (rnd) {req, code, rush} = {r[30], tab[r[3:0] % 9], &{r[31], r[18], r[20]}};
        end
    endtask : cyc
    // Expected outputs for the next cycle, from inputs stable at this edge
    always @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            {e_int, e_aer, e_cap, e_serr, e_val, e_func, ldet, e_viol} = '0;
            e_since = CPL_SPACING;
            foreach (e_st[i]) e_st[i] = 6'h00;
        end
        else
        begin
            e_int = (e_int | INTX_ASSERT_IN) & ~INTX_DEASSERT_IN;
            e_aer = AER_MSI_NUM_IN & MSI_NUM_EN_IN;
            e_cap = CAP_MSI_NUM_IN & MSI_NUM_EN_IN;
            e_serr = SYS_ERR_DET_IN & !ldet & ROOT_SERR_EN_IN & DEV_SERR_EN_IN;
            ldet = SYS_ERR_DET_IN;
            e_val = CPL_ERR_IN[5:0] != 6'h00;
            e_since++;
            e_viol = e_val && e_since < CPL_SPACING;
            if (e_val) e_since = 0;
            e_kind = CPL_ERR_IN[5:1] != 5'h00 ? MSG_NONFATAL : MSG_COR;
            {e_ck, e_adv} = {e_val && CPL_ERR_IN[5:2] == 4'h0, !CPL_ERR_IN[1]};
            if (e_val) e_func = CPL_ERR_FUNC_IN;
            if (STATUS_CLR_IN) e_st[STATUS_CLR_FUNC_IN] = 6'h00;
            e_st[CPL_ERR_FUNC_IN] |= CPL_ERR_IN[5:0];
        end
    end
    always @(negedge CLK_IN)
    begin
        if (RST_B_IN)
        begin
            chk("int_status", e_int, INT_STATUS_OUT);
            chk("aer_data", e_aer, AER_MSI_DATA_OUT);
            chk("cap_data", e_cap, CAP_MSI_DATA_OUT);
            chk("serr", e_serr, SERR_OUT);
            chk("msg_valid", e_val, ERR_MSG_VALID_OUT);
            chk("msg_func", e_func, ERR_MSG_FUNC_OUT);
            chk("spacing", e_viol, CPL_ERR_SPACING_VIOL_OUT);
            if (e_val) chk("msg_kind", e_kind, ERR_MSG_KIND_OUT);
            if (e_ck) chk("advisory", e_adv, ERR_MSG_ADVISORY_OUT);
            foreach (e_st[i]) chk("status", e_st[i], ERR_STATUS_OUT[i]);
        end
    end
    task automatic finish_test();
        $display("TB counts: %0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        {INTX_ASSERT_IN, INTX_DEASSERT_IN, AER_MSI_NUM_IN, CAP_MSI_NUM_IN, MSI_NUM_EN_IN} = '0;
        {SYS_ERR_DET_IN, ROOT_SERR_EN_IN, DEV_SERR_EN_IN, STATUS_CLR_IN} = '0;
        {STATUS_CLR_FUNC_IN, func} = '0;
        repeat (10) @(posedge CLK_IN);
        #1 RST_B_IN = 1'b1;
        foreach (tab[i])
        begin
            {req, code} = {1'b1, tab[i]};
            cyc(8, 1'b0);
        end
        $display("TB test error codes done");
        {req, rush, code} = {2'b11, 7'h02};
        cyc(3, 1'b0);
        rush = 1'b0;
        $display("TB test spacing burst done");
        cyc(3000, 1'b1);
        $display("TB test random traffic done");
        finish_test();
    end
endmodule : rp_sideband_tb
